/* File: src/pau_regs.vh */
// Constants for the process alarm unit: alarm types, latch modes,
// timing counts and default routing. Included by the design files.
`ifndef PAU_REGS_VH
`define PAU_REGS_VH

// Alarm type codes, 3 bits
`define PAU_TYP_NONE   3'h0
`define PAU_TYP_FS_HI  3'h1
`define PAU_TYP_FS_LO  3'h2
`define PAU_TYP_DV_HI  3'h3
`define PAU_TYP_DV_LO  3'h4
`define PAU_TYP_BAND   3'h5
`define PAU_TYP_RISE   3'h6
`define PAU_TYP_FALL   3'h7

// Latch mode codes, 2 bits
`define PAU_LAT_NONE   2'h0
`define PAU_LAT_AUTO   2'h1
`define PAU_LAT_OPER   2'h2
`define PAU_LAT_EVENT  2'h3

// Data width of process value and thresholds
`define PAU_DW         16

// Clock rate and timing
`define PAU_CLK_HZ     200000000
`define PAU_RSP_TMO_S  5
`define PAU_RSP_TMO_CYC (`PAU_CLK_HZ * `PAU_RSP_TMO_S)
`define PAU_RATE_WIN_S 60
`define PAU_RATE_CYC   (`PAU_CLK_HZ * `PAU_RATE_WIN_S)
`define PAU_MSG_DWELL_MS 2000
`define PAU_MSG_CYC    (`PAU_CLK_HZ / 1000 * `PAU_MSG_DWELL_MS)
`define PAU_FLASH_MS   500
`define PAU_FLASH_CYC  (`PAU_CLK_HZ / 1000 * `PAU_FLASH_MS)

// Default routing: output n follows alarm n
`define PAU_ROUTE_DEF  16'h8421

`endif

/* File: src/pau_alarm_ch.v */
// One threshold alarm channel: compare, hysteresis, blocking, latching.
// Assumes the threshold values are stable and ack is a one-cycle pulse.
`timescale 1ns/1ps
`include "pau_regs.vh"

module pau_alarm_ch (
	input  wire                    clk,
	input  wire                    rst_b,
	input  wire [2:0]              alarm_type,
	input  wire [1:0]              latch_mode,
	input  wire                    block_en,
	input  wire signed [15:0]      threshold,
	input  wire [15:0]             hysteresis,
	input  wire signed [15:0]      process_value,
	input  wire signed [15:0]      setpoint_value,
	input  wire signed [16:0]      rate_per_min,
	input  wire                    sp_changed,
	input  wire                    ack,
	output reg                     active_ff,
	output reg                     unacked_ff,
	output reg                     cond_ff
);

	reg                blocked_ff;
	reg signed [17:0]  val;
	reg signed [17:0]  lim;
	reg                over_on;
	reg                over_off;
	reg                nxt_cond;
	reg                nxt_active;
	reg                nxt_unacked;
	reg                nxt_blocked;
	wire               cfg_ok;
	wire signed [17:0] dev;
	wire signed [17:0] hys;

	assign cfg_ok = (alarm_type != `PAU_TYP_NONE);
	assign dev = {{2{process_value[15]}}, process_value}
		- {{2{setpoint_value[15]}}, setpoint_value};
	assign hys = {2'b00, hysteresis};

	// Select the measured quantity and the sense of comparison
	always @* begin
		val = 18'sd0;
		lim = {{2{threshold[15]}}, threshold};
		case (alarm_type)
			`PAU_TYP_FS_HI: val = {{2{process_value[15]}}, process_value};
			`PAU_TYP_FS_LO: val = -{{2{process_value[15]}}, process_value};
			`PAU_TYP_DV_HI: val = dev;
			`PAU_TYP_DV_LO: val = -dev;
			`PAU_TYP_BAND:  val = dev[17] ? -dev : dev;
			`PAU_TYP_RISE:  val = {rate_per_min[16], rate_per_min};
			`PAU_TYP_FALL:  val = -{rate_per_min[16], rate_per_min};
			default:        val = 18'sd0;
		endcase
		// Low limits are mirrored so one greater-than test serves all
		if (alarm_type == `PAU_TYP_FS_LO || alarm_type == `PAU_TYP_DV_LO)
			lim = -lim;
		over_on  = (val > lim);
		over_off = (val > lim - hys);
		nxt_cond = cfg_ok & (cond_ff ? over_off : over_on);
	end

	// Blocking, latching and acknowledge
	always @* begin
		nxt_blocked = blocked_ff;
		nxt_active  = active_ff;
		nxt_unacked = unacked_ff;
		if (!block_en || !nxt_cond)
			nxt_blocked = 1'b0;
		if (block_en && sp_changed)
			nxt_blocked = 1'b1;
		if (!cfg_ok) begin
			nxt_active  = 1'b0;
			nxt_unacked = 1'b0;
		end else if (nxt_cond && !blocked_ff && !active_ff) begin
			nxt_active  = 1'b1;
			nxt_unacked = 1'b1;
		end else begin
			case (latch_mode)
				`PAU_LAT_AUTO: begin
					if (ack)
						nxt_unacked = 1'b0;
					if (!nxt_cond && (!unacked_ff || ack))
						nxt_active = 1'b0;
				end
				`PAU_LAT_OPER: begin
					if (ack && !nxt_cond) begin
						nxt_unacked = 1'b0;
						nxt_active  = 1'b0;
					end
				end
				default: begin
					if (ack)
						nxt_unacked = 1'b0;
					if (!nxt_cond) begin
						nxt_active  = 1'b0;
						nxt_unacked = 1'b0;
					end
				end
			endcase
		end
	end

	// State registers
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cond_ff    <= 1'b0;
			active_ff  <= 1'b0;
			unacked_ff <= 1'b0;
			blocked_ff <= 1'b1;
		end else begin
			cond_ff    <= nxt_cond;
			active_ff  <= nxt_active;
			unacked_ff <= nxt_unacked;
			blocked_ff <= nxt_blocked;
		end
	end

endmodule

/* File: src/pau_top.v */
// Process alarm unit top: four threshold alarms, rate measurement,
// output routing, beacon and message sequencing, and the sensor-break,
// loop-break and remote-setpoint timeout alarms.
// Assumes all inputs are synchronous to clk; ack is a one-cycle pulse.
//
// Behaviour
// - Four configurable alarms; unconfigured never activates
// - Unconfigured alarm gives no indication or output
// - Hysteresis separates turn-off level from turn-on
// - Non-latching alarm clears when condition goes
// - Auto latch: ack accepted early, clears later
// - Operator latch: ack ignored while condition persists
// - Event: beacon dark, output driven, message
// - Blocking suppresses alarm until first safe state
// - Setpoint change re-arms blocking
// - Rate alarms compare change over the RATE_CYC window (about 17 s by default) to threshold
// - Each output combines any of four alarms
// - Default routing: output n follows alarm n
// - Beacon flashes unacknowledged, steady once acknowledged
// - Messages cycle in turn while alarms present
// - Acked non-latching: beacon steady, message continues
// - Relay de-energises on alarm until ack/clear
// - Non-latching alarm resets if condition goes first
// - Sensor break raises alarm, forces safe output
// - Loop break: demand changes, PV static, delay
// - Remote fail after 5 s without new value
`timescale 1ns/1ps
`include "pau_regs.vh"

module pau_top #(
	parameter [31:0] RATE_CYC   = `PAU_RATE_CYC,
	parameter [31:0] RSP_CYC    = `PAU_RSP_TMO_CYC,
	parameter [31:0] LOOP_CYC   = 32'd1000000000,
	parameter [31:0] MSG_CYC    = `PAU_MSG_CYC,
	parameter [31:0] FLASH_CYC  = `PAU_FLASH_CYC
) (
	input  wire                clk,
	input  wire                rst_b,
	input  wire signed [15:0]  process_value,
	input  wire signed [15:0]  setpoint_value,
	input  wire                ack,
	input  wire [11:0]         alarm_type_cfg,
	input  wire [7:0]          latch_mode_cfg,
	input  wire [3:0]          block_en_cfg,
	input  wire [63:0]         threshold_cfg,
	input  wire [63:0]         hysteresis_cfg,
	input  wire                route_load,
	input  wire [15:0]         route_cfg,
	input  wire                sensor_open,
	input  wire [7:0]          demand_in,
	input  wire [7:0]          safe_level,
	input  wire                remote_en,
	input  wire                remote_strobe,
	output reg  [7:0]          control_out_ff,
	output reg  [3:0]          relay_energised_ff,
	output reg                 alarm_beacon_ff,
	output reg                 message_valid_ff,
	output reg  [2:0]          message_sel_ff,
	output wire [3:0]          alarm_active,
	output reg                 sensor_break_ff,
	output reg                 loop_break_ff,
	output reg                 remote_fail_ff
);

	// Message source codes: 0..3 threshold alarms, 4..6 system alarms
	localparam [2:0] MSG_SBR = 3'h4;
	localparam [2:0] MSG_LBR = 3'h5;
	localparam [2:0] MSG_RSP = 3'h6;

	reg  [15:0]        route_ff;
	reg  signed [15:0] sp_last_ff;
	reg  signed [15:0] pv_mark_ff;
	reg  signed [16:0] rate_ff;
	reg  [31:0]        rate_cnt_ff;
	reg  [31:0]        rsp_cnt_ff;
	reg  [31:0]        loop_cnt_ff;
	reg  [7:0]         demand_last_ff;
	reg  signed [15:0] pv_loop_ff;
	reg                loop_arm_ff;
	reg  [31:0]        msg_cnt_ff;
	reg  [31:0]        flash_cnt_ff;
	reg                flash_ff;
	reg  [3:0]         relay_drive;
	reg  [2:0]         nxt_msg;
	reg                found;
	integer            i;
	integer            k;
	wire               sp_changed;
	wire [3:0]         unacked;
	wire [3:0]         cond;
	wire [6:0]         msg_req;
	wire               any_unacked;
	wire               any_beacon;

	assign sp_changed = (setpoint_value != sp_last_ff);

	// Four identical alarm channels
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : ch
			pau_alarm_ch u_ch (
				.clk            (clk),
				.rst_b          (rst_b),
				.alarm_type     (alarm_type_cfg[3*g +: 3]),
				.latch_mode     (latch_mode_cfg[2*g +: 2]),
				.block_en       (block_en_cfg[g]),
				.threshold      (threshold_cfg[16*g +: 16]),
				.hysteresis     (hysteresis_cfg[16*g +: 16]),
				.process_value  (process_value),
				.setpoint_value (setpoint_value),
				.rate_per_min   (rate_ff),
				.sp_changed     (sp_changed),
				.ack            (ack),
				.active_ff      (alarm_active[g]),
				.unacked_ff     (unacked[g]),
				.cond_ff        (cond[g])
			);
		end
	endgenerate

	// True when a channel lights the beacon (event mode never does)
	function is_beacon;
		input       act;
		input [1:0] mode;
		begin
			is_beacon = act && (mode != `PAU_LAT_EVENT);
		end
	endfunction

	assign any_unacked = |(unacked & alarm_active)
		| sensor_break_ff | loop_break_ff | remote_fail_ff;
	assign any_beacon = is_beacon(alarm_active[0], latch_mode_cfg[1:0])
		| is_beacon(alarm_active[1], latch_mode_cfg[3:2])
		| is_beacon(alarm_active[2], latch_mode_cfg[5:4])
		| is_beacon(alarm_active[3], latch_mode_cfg[7:6])
		| sensor_break_ff | loop_break_ff | remote_fail_ff;

	// Event alarms show a message only while their condition holds
	assign msg_req[0] = alarm_active[0] & ((latch_mode_cfg[1:0]
		!= `PAU_LAT_EVENT) | cond[0]);
	assign msg_req[1] = alarm_active[1] & ((latch_mode_cfg[3:2]
		!= `PAU_LAT_EVENT) | cond[1]);
	assign msg_req[2] = alarm_active[2] & ((latch_mode_cfg[5:4]
		!= `PAU_LAT_EVENT) | cond[2]);
	assign msg_req[3] = alarm_active[3] & ((latch_mode_cfg[7:6]
		!= `PAU_LAT_EVENT) | cond[3]);
	assign msg_req[4] = sensor_break_ff;
	assign msg_req[5] = loop_break_ff;
	assign msg_req[6] = remote_fail_ff;

	// Relay drive: OR of routed alarms; relay drops out while a
	// routed non-latching alarm is active and unacknowledged
	always @* begin
		for (i = 0; i < 4; i = i + 1) begin
			relay_drive[i] = 1'b0;
			for (k = 0; k < 4; k = k + 1) begin
				if (route_ff[4*i + k] && alarm_active[k]) begin
					if (latch_mode_cfg[2*k +: 2] == `PAU_LAT_NONE)
						relay_drive[i] = relay_drive[i]
							| unacked[k];
					else
						relay_drive[i] = 1'b1;
				end
			end
		end
	end

	// Next message in rotation after the one shown
	always @* begin
		nxt_msg = message_sel_ff;
		found   = 1'b0;
		for (i = 1; i <= 7; i = i + 1) begin
			k = (message_sel_ff + i) % 7;
			if (!found && msg_req[k]) begin
				nxt_msg = k[2:0];
				found   = 1'b1;
			end
		end
	end

	// Routing, rate measurement and setpoint tracking
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			route_ff    <= `PAU_ROUTE_DEF;
			sp_last_ff  <= 16'sh0000;
			pv_mark_ff  <= 16'sh0000;
			rate_ff     <= 17'sh00000;
			rate_cnt_ff <= 32'h00000000;
		end else begin
			if (route_load)
				route_ff <= route_cfg;
			sp_last_ff <= setpoint_value;
			// Change over a RATE_CYC window, by default 3410065408 cycles (about 17 s);
			// trades response time for a simple subtractor
			if (rate_cnt_ff >= RATE_CYC - 32'h1) begin
				rate_cnt_ff <= 32'h00000000;
				rate_ff <= {process_value[15], process_value}
					- {pv_mark_ff[15], pv_mark_ff};
				pv_mark_ff <= process_value;
			end else begin
				rate_cnt_ff <= rate_cnt_ff + 32'h1;
			end
		end
	end

	// Sensor break, loop break and remote setpoint timeout
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sensor_break_ff <= 1'b0;
			control_out_ff  <= 8'h00;
			remote_fail_ff  <= 1'b0;
			rsp_cnt_ff      <= 32'h00000000;
			loop_break_ff   <= 1'b0;
			loop_cnt_ff     <= 32'h00000000;
			loop_arm_ff     <= 1'b0;
			demand_last_ff  <= 8'h00;
			pv_loop_ff      <= 16'sh0000;
		end else begin
			sensor_break_ff <= sensor_open;
			control_out_ff  <= sensor_open ? safe_level : demand_in;
			if (!remote_en || remote_strobe) begin
				rsp_cnt_ff     <= 32'h00000000;
				remote_fail_ff <= 1'b0;
			end else if (rsp_cnt_ff >= RSP_CYC - 32'h1) begin
				remote_fail_ff <= 1'b1;
			end else begin
				rsp_cnt_ff <= rsp_cnt_ff + 32'h1;
			end
			demand_last_ff <= demand_in;
			if (demand_in != demand_last_ff) begin
				loop_arm_ff <= 1'b1;
				loop_cnt_ff <= 32'h00000000;
				pv_loop_ff  <= process_value;
			end else if (process_value != pv_loop_ff) begin
				loop_arm_ff   <= 1'b0;
				loop_break_ff <= 1'b0;
			end else if (loop_arm_ff) begin
				if (loop_cnt_ff >= LOOP_CYC - 32'h1)
					loop_break_ff <= 1'b1;
				else
					loop_cnt_ff <= loop_cnt_ff + 32'h1;
			end
		end
	end

	// Beacon, message rotation and relay outputs
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			flash_cnt_ff       <= 32'h00000000;
			flash_ff           <= 1'b0;
			msg_cnt_ff         <= 32'h00000000;
			message_sel_ff     <= 3'h0;
			message_valid_ff   <= 1'b0;
			alarm_beacon_ff    <= 1'b0;
			relay_energised_ff <= 4'hf;
		end else begin
			if (flash_cnt_ff >= FLASH_CYC - 32'h1) begin
				flash_cnt_ff <= 32'h00000000;
				flash_ff     <= ~flash_ff;
			end else begin
				flash_cnt_ff <= flash_cnt_ff + 32'h1;
			end
			// Flash while unacked, steady once acked
			alarm_beacon_ff <= any_beacon
				& (any_unacked ? flash_ff : 1'b1);
			message_valid_ff <= |msg_req;
			if (!msg_req[message_sel_ff] ||
				msg_cnt_ff >= MSG_CYC - 32'h1) begin
				msg_cnt_ff     <= 32'h00000000;
				message_sel_ff <= nxt_msg;
			end else begin
				msg_cnt_ff <= msg_cnt_ff + 32'h1;
			end
			// Relays fail-safe: energised in the healthy state
			relay_energised_ff <= ~relay_drive;
		end
	end

endmodule

/* File: tb/pau_checker.sv */
// Port-level timing checks for the process alarm unit top.
// Assumes a bind onto pau_top with RSP_CYC handed on.
`timescale 1ns/1ps
`include "pau_regs.vh"

module pau_checker #(
	parameter [31:0] RSP_CYC = 32'd50
) (
	input wire               clk,
	input wire               rst_b,
	input wire signed [15:0] process_value,
	input wire [11:0]        alarm_type_cfg,
	input wire [7:0]         latch_mode_cfg,
	input wire [3:0]         block_en_cfg,
	input wire [63:0]        threshold_cfg,
	input wire [63:0]        hysteresis_cfg,
	input wire               sensor_open,
	input wire [7:0]         demand_in,
	input wire [7:0]         safe_level,
	input wire               remote_en,
	input wire               remote_strobe,
	input wire [7:0]         control_out_ff,
	input wire [3:0]         relay_energised_ff,
	input wire               alarm_beacon_ff,
	input wire               message_valid_ff,
	input wire [3:0]         alarm_active,
	input wire               sensor_break_ff,
	input wire               loop_break_ff,
	input wire               remote_fail_ff
);
	// Alarm one as plain full-scale high, no latch, no blocking
	wire signed [16:0] thr0 = $signed(threshold_cfg[15:0]);
	wire signed [16:0] off0 = thr0 - $signed({1'b0, hysteresis_cfg[15:0]});
	wire cf0 = alarm_type_cfg[2:0] == `PAU_TYP_FS_HI &&
		latch_mode_cfg[1:0] == `PAU_LAT_NONE && !block_en_cfg[0];
	wire quiet = alarm_active == 4'h0 && !sensor_break_ff &&
		!loop_break_ff && !remote_fail_ff;
	reg [31:0] gap_ff;

	// Cycles since last remote value; saturates to avoid wrap
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			gap_ff <= 32'h0;
		else if (!remote_en || remote_strobe)
			gap_ff <= 32'h0;
		else if (gap_ff != 32'hffffffff)
			gap_ff <= gap_ff + 32'h1;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	AST_SAFE: assert property (sensor_open |=>
		control_out_ff == $past(safe_level) && sensor_break_ff)
		else $error("safe level not forced");
	AST_PASS: assert property (!sensor_open |=>
		control_out_ff == $past(demand_in))
		else $error("demand not passed through");
	AST_UNCFG: assert property (
		(alarm_type_cfg[11:9] == `PAU_TYP_NONE)[*2] |-> !alarm_active[3])
		else $error("unconfigured alarm active");
	AST_RLY_IDLE: assert property (
		(alarm_active == 4'h0)[*2] |-> relay_energised_ff == 4'hf)
		else $error("relay dropped with no alarm");
	AST_DARK: assert property (quiet[*2] |-> !alarm_beacon_ff)
		else $error("beacon lit with no alarm");
	AST_MSG_OFF: assert property (quiet[*2] |-> !message_valid_ff)
		else $error("message shown with no alarm");
	AST_ON: assert property (cf0 && process_value > thr0 |=>
		alarm_active[0]) else $error("high alarm not raised");
	AST_HOLD: assert property (
		cf0 && alarm_active[0] && process_value > off0 |=> alarm_active[0])
		else $error("alarm dropped inside hysteresis");
	AST_CLR: assert property (cf0 && process_value <= off0 |=>
		!alarm_active[0]) else $error("non-latching alarm stuck");
	AST_RFAIL: assert property (gap_ff > RSP_CYC + 32'd1 |->
		remote_fail_ff) else $error("remote timeout missed");

	// Main scenarios reached
	cover property (alarm_active == 4'h7);
	cover property (sensor_break_ff);
	cover property (remote_fail_ff);
endmodule

/* File: tb/pau_panel.sv */
// Operator panel and sensor model: acknowledge key and open circuit.
// Assumes bench requests change just after rising edges.
`timescale 1ns/1ps

module pau_panel (
	input  wire clk,
	input  wire rst_b,
	input  wire ack_req,
	input  wire break_req,
	output reg  ack_ff,
	output reg  sensor_open_ff
);
	reg req_ff;

	// Key press gives one pulse however long it is held
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			req_ff         <= 1'b0;
			ack_ff         <= 1'b0;
			sensor_open_ff <= 1'b0;
		end else begin
			req_ff         <= ack_req;
			ack_ff         <= ack_req & ~req_ff;
			sensor_open_ff <= break_req;
		end
	end
endmodule

/* File: tb/pau_top_tb.sv */
// Bench for the alarm unit: port drive sequences with expectations.
// Assumes the panel model for ack and sensor; short timing counts.
`timescale 1ns/1ps

module pau_top_tb;
	reg               clk = 1'b0;
	reg               rst_b = 1'b0;
	reg signed [15:0] pv = 16'h00c8;
	reg signed [15:0] sp = 16'h0000;
	reg [11:0]        typ = 12'h000;
	reg [7:0]         lat = 8'h18;
	reg [3:0]         blk = 4'h0;
	reg [7:0]         dem = 8'h33;
	reg               rem_en = 1'b0;
	reg               rem_stb = 1'b0;
	reg               rload = 1'b0;
	reg [15:0]        rcfg = 16'h0000;
	reg               ack_req = 1'b0;
	reg               brk_req = 1'b0;
	wire              ack;
	wire              sen;
	wire [7:0]        ctl;
	wire [3:0]        rly;
	wire [3:0]        act;
	wire              sbr;
	wire              rfl;
	wire              bcn;
	wire              msgv;
	wire [2:0]        msel;
	wire              lbr;
	integer           n_errors = 0;
	integer           checked = 0;
	integer           w;

	// Free-running 200 MHz clock
	initial begin
		forever #2.5 clk = ~clk;
	end

	pau_panel i_pau_panel (.clk(clk), .rst_b(rst_b), .ack_req(ack_req),
		.break_req(brk_req), .ack_ff(ack), .sensor_open_ff(sen));

	// Short counts keep the run brief
	pau_top #(.RATE_CYC(32'd100), .RSP_CYC(32'd50), .LOOP_CYC(32'd50),
		.MSG_CYC(32'd20), .FLASH_CYC(32'd4)) i_pau_top (
		.clk(clk), .rst_b(rst_b), .process_value(pv),
		.setpoint_value(sp), .ack(ack), .alarm_type_cfg(typ),
		.latch_mode_cfg(lat), .block_en_cfg(blk),
		.threshold_cfg(64'h0014006400640064),
		.hysteresis_cfg(64'h0000000a000a000a), .route_load(rload),
		.route_cfg(rcfg), .sensor_open(sen), .demand_in(dem),
		.safe_level(8'h5a), .remote_en(rem_en), .remote_strobe(rem_stb),
		.control_out_ff(ctl), .relay_energised_ff(rly),
		.alarm_beacon_ff(bcn), .message_valid_ff(msgv),
		.message_sel_ff(msel), .alarm_active(act),
		.sensor_break_ff(sbr), .loop_break_ff(lbr),
		.remote_fail_ff(rfl));

	task chk(input [15:0] seen, input [15:0] exp);
		begin
			checked = checked + 1;
			if (seen !== exp) begin
				n_errors = n_errors + 1;
				$display("BAD %0t seen %h expected %h", $time, seen, exp);
			end
		end
	endtask

	// Let n edges pass, then sample settled outputs
	task look(input integer n);
		begin
			repeat (n) @(posedge clk);
			#1;
		end
	endtask

	task ackp;
		begin
			@(posedge clk) ack_req <= 1'b1;
			@(posedge clk) ack_req <= 1'b0;
			look(4);
		end
	endtask

	task stb;
		begin
			@(posedge clk) rem_stb <= 1'b1;
			@(posedge clk) rem_stb <= 1'b0;
			repeat (8) @(posedge clk);
		end
	endtask

	task complete_run;
		begin
			$display("checks %0d mismatches %0d", checked, n_errors);
			if (n_errors == 0 && checked > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask

	initial begin
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		look(3);
		chk(act, 16'h0000);
		chk(rly, 16'h000f);
		// Alarms one to three full-scale high: none, manual, auto latch
		@(posedge clk) typ <= 12'h049;
		pv <= 16'h0065;
		look(3);
		chk(act, 16'h0007);
		chk(rly, 16'h0008);
		chk(msgv, 16'h0001);
		@(posedge clk) pv <= 16'h005f;
		look(3);
		chk(act, 16'h0007);
		ackp;
		chk(act, 16'h0007);
		chk(rly, 16'h0009);
		@(posedge clk) pv <= 16'h005a;
		look(3);
		chk(act, 16'h0002);
		chk(rly, 16'h000d);
		ackp;
		chk(act, 16'h0000);
		chk(rly, 16'h000f);
		// Output two fed by alarms one to three; clear before ack
		@(posedge clk) rload <= 1'b1;
		rcfg <= 16'h0070;
		@(posedge clk) rload <= 1'b0;
		pv <= 16'h0065;
		look(3);
		chk(rly, 16'h000d);
		@(posedge clk) pv <= 16'h005a;
		look(3);
		chk(act, 16'h0006);
		ackp;
		chk(act, 16'h0000);
		// Alarm four as band around the setpoint
		@(posedge clk) typ <= 12'ha49;
		pv <= 16'h0000;
		sp <= 16'h001e;
		look(3);
		chk(act, 16'h0008);
		@(posedge clk) sp <= 16'h0000;
		look(3);
		chk(act, 16'h0000);
		chk(bcn, 16'h0000);
		chk(msgv, 16'h0000);
		// Sensor break forces the safe level
		@(posedge clk) dem <= 8'h44;
		look(3);
		chk(ctl, 16'h0044);
		@(posedge clk) brk_req <= 1'b1;
		look(3);
		chk(ctl, 16'h005a);
		chk(sbr, 16'h0001);
		@(posedge clk) brk_req <= 1'b0;
		look(3);
		chk(sbr, 16'h0000);
		// Remote values arrive, then stop
		@(posedge clk) rem_en <= 1'b1;
		repeat (5) stb;
		look(1);
		chk(rfl, 16'h0000);
		w = 0;
		while (rfl !== 1'b1 && w < 200) begin
			@(posedge clk);
			w = w + 1;
		end
		// Demand moved earlier while the process value stayed put
		chk(lbr, 16'h0001);
		if (w >= 200)
			n_errors = n_errors + 1;
		else
			chk(w > 30, 16'h0001);
		complete_run;
	end
endmodule

bind pau_top pau_checker #(.RSP_CYC(RSP_CYC)) i_pau_checker (
	.clk(clk), .rst_b(rst_b), .process_value(process_value),
	.alarm_type_cfg(alarm_type_cfg), .latch_mode_cfg(latch_mode_cfg),
	.block_en_cfg(block_en_cfg), .threshold_cfg(threshold_cfg),
	.hysteresis_cfg(hysteresis_cfg), .sensor_open(sensor_open),
	.demand_in(demand_in), .safe_level(safe_level),
	.remote_en(remote_en), .remote_strobe(remote_strobe),
	.control_out_ff(control_out_ff),
	.relay_energised_ff(relay_energised_ff),
	.alarm_beacon_ff(alarm_beacon_ff),
	.message_valid_ff(message_valid_ff), .alarm_active(alarm_active),
	.sensor_break_ff(sensor_break_ff), .loop_break_ff(loop_break_ff),
	.remote_fail_ff(remote_fail_ff));
